/* core/ushp_pkg.sv */
// Package with constants, state type and reset value of the serial host port.
// Summary of operation
// - A select pin chooses I2C slave or SPI slave operation.
// - I2C runs at Standard-mode 100 kbps and Fast-mode 400 kbps.
// - Each byte written to the device, except a refused transmit FIFO write, is acknowledged by pulling SDA low.
// - A write to a full transmit FIFO is answered with no acknowledge.
// - Address is 0110 plus three bits decoded from two four-level straps.
// - Address byte bit 0 is the direction, high read, low write.
// - Sub-address bits 6:3 register, bits 2:1 channel, 00 only valid.
// - SPI uses clock, active-low select, slave out, slave in, up to 5 Mbps.
// - First SPI byte: bit 7 direction, 6:3 register, 2:1 channel.
// - A reset pulse over 40 ns returns registers and outputs to defaults.
// - Transmit interrupt pin follows holding register or trigger level normally.
// - In line direction mode it goes low on empty transmitter, and with FIFOs enabled also below the transmit trigger level.
// - Receive interrupt pin follows held data or the receive trigger level.
package ushp_pkg;

  localparam logic [3:0] I2C_ADDR_PREFIX  = 4'h6;
  localparam logic [3:0] REG_ADDR_THR     = 4'h0;
  localparam logic [1:0] CHAN_VALID       = 2'h0;
  localparam logic [7:0] READ_FILL        = 8'hFF;
  localparam logic [2:0] LAST_BIT         = 3'h7;
  localparam logic [1:0] STRAP_VCC        = 2'h0;
  localparam logic [1:0] STRAP_GND        = 2'h1;
  localparam logic [1:0] STRAP_SCL        = 2'h2;
  localparam logic [1:0] STRAP_SDA        = 2'h3;
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         RESET_PULSE_NS   = 40;
  localparam int         RESET_PULSE_CYC  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         I2C_FAST_KBPS    = 400;
  localparam int         SPI_MAX_KBPS     = 5000;

  typedef enum logic [3:0] {
    PH_IDLE, PH_DEVADDR, PH_SUBADDR, PH_WDATA, PH_RDATA, PH_RD_MACK,
    PH_RD_NEXT, PH_IGNORE, PH_SPI_CMD, PH_SPI_DATA
  } ushp_phase_t;

  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic [1:0]  cs_s;
    logic [1:0]  si_s;
    logic [1:0]  sel_s;
    logic [1:0]  sh_s;
    logic [1:0]  sl_s;
    logic [1:0]  live;
    logic        scl_d;
    logic        sda_d;
    logic        cs_d;
    logic [1:0]  sh_diff;
    logic [1:0]  sl_diff;
    ushp_phase_t ph;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txreg;
    logic [7:0]  wdata;
    logic [3:0]  raddr;
    logic        chan_ok;
    logic        rd;
    logic        in_ack;
    logic        ack_drv;
    logic        do_ack;
    logic        sda_drv;
    logic        so;
    logic        wr_pulse;
    logic        rd_pulse;
    logic        irq_tx_n;
    logic        irq_rx_n;
  } ushp_state_t;

  localparam ushp_state_t STATE_RST = '{
    scl_s: 2'h3, sda_s: 2'h3, cs_s: 2'h3, si_s: 2'h0, sel_s: 2'h0, sh_s: 2'h3,
    sl_s: 2'h3, live: 2'h0, scl_d: 1'b1, sda_d: 1'b1, cs_d: 1'b1, sh_diff: 2'h0,
    sl_diff: 2'h0, ph: PH_IDLE, bitcnt: 3'h0, shreg: 8'h00, txreg: 8'h00,
    wdata: 8'h00, raddr: 4'h0, chan_ok: 1'b0, rd: 1'b0, in_ack: 1'b0,
    ack_drv: 1'b0, do_ack: 1'b0, sda_drv: 1'b0, so: 1'b0, wr_pulse: 1'b0,
    rd_pulse: 1'b0, irq_tx_n: 1'b0, irq_rx_n: 1'b1};

endpackage

/* core/ushp_serial_host_port.sv */
// Selectable I2C or SPI slave host port with interrupt pin levels.
`timescale 1ns/1ps
module ushp_serial_host_port
  import ushp_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Interface select and address straps.
  input  wire logic       i2c_spi_n_sel_i,
  input  wire logic       address_strap_high_i,
  input  wire logic       address_strap_low_i,
  // Serial pins.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  output logic            so_o,
  // Register access towards the UART core.
  output logic [3:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       tx_fifo_full_i,
  // Interrupt pin conditions.
  input  wire logic       fifo_enable_i,
  input  wire logic       auto_line_direction_mode_i,
  input  wire logic       thr_full_i,
  input  wire logic       tx_above_trigger_i,
  input  wire logic       transmitter_empty_i,
  input  wire logic       rx_data_held_i,
  input  wire logic       rx_above_trigger_i,
  output logic            irq_tx_n_o,
  output logic            irq_rx_n_o
);

  ushp_state_t q;
  ushp_state_t d;

  logic       sel;
  logic       scl;
  logic       sda;
  logic       cs;
  logic       din;
  logic       scl_rise;
  logic       scl_fall;
  logic       i2c_start;
  logic       i2c_stop;
  logic       refuse;
  logic [7:0] byte_in;
  logic [1:0] hi_code;
  logic [1:0] lo_code;
  logic [6:0] dev_addr;

  function automatic logic [1:0] strap_code(input logic lvl, input logic [1:0] diff);
    logic [1:0] code;
    code = lvl ? STRAP_VCC : STRAP_GND;
    if (!diff[0]) begin
      code = STRAP_SCL;
    end else if (!diff[1]) begin
      code = STRAP_SDA;
    end
    return code;
  endfunction

  assign sel       = q.sel_s[1];
  assign scl       = q.scl_s[1];
  assign sda       = q.sda_s[1];
  assign cs        = q.cs_s[1];
  assign din       = sel ? sda : q.si_s[1];
  assign scl_rise  = scl && !q.scl_d;
  assign scl_fall  = !scl && q.scl_d;
  assign i2c_start = scl && q.scl_d && q.sda_d && !sda;
  assign i2c_stop  = scl && q.scl_d && !q.sda_d && sda;
  assign byte_in   = {q.shreg[6:0], din};
  assign refuse    = (q.raddr == REG_ADDR_THR) && tx_fifo_full_i;
  assign hi_code   = strap_code(q.sh_s[1], q.sh_diff);
  assign lo_code   = strap_code(q.sl_s[1], q.sl_diff);
  assign dev_addr  = {I2C_ADDR_PREFIX, hi_code[0], lo_code};

  always_comb begin
    d = q;
    d.scl_s    = {q.scl_s[0], scl_i};
    d.sda_s    = {q.sda_s[0], sda_i};
    d.cs_s     = {q.cs_s[0], cs_n_i};
    d.si_s     = {q.si_s[0], si_i};
    d.sel_s    = {q.sel_s[0], i2c_spi_n_sel_i};
    d.sh_s     = {q.sh_s[0], address_strap_high_i};
    d.sl_s     = {q.sl_s[0], address_strap_low_i};
    d.live     = {q.live[0], 1'b1};
    d.scl_d    = scl;
    d.sda_d    = sda;
    d.cs_d     = cs;
    d.wr_pulse = 1'b0;
    d.rd_pulse = 1'b0;
    // A strap that ever differs from SCL or SDA is not tied to it.
    if (q.live[1] && sel) begin
      d.sh_diff = q.sh_diff | {q.sh_s[1] != sda, q.sh_s[1] != scl};
      d.sl_diff = q.sl_diff | {q.sl_s[1] != sda, q.sl_s[1] != scl};
    end
    if (q.rd_pulse) begin
      d.txreg = q.chan_ok ? reg_rdata_i : READ_FILL;
    end
    if (auto_line_direction_mode_i) begin
      d.irq_tx_n = fifo_enable_i ? (tx_above_trigger_i && !transmitter_empty_i)
                                 : !transmitter_empty_i;
    end else begin
      d.irq_tx_n = fifo_enable_i ? tx_above_trigger_i : thr_full_i;
    end
    d.irq_rx_n = fifo_enable_i ? !rx_above_trigger_i : !rx_data_held_i;
    if (sel) begin
      if (i2c_start) begin
        d.ph      = PH_DEVADDR;
        d.bitcnt  = 3'h0;
        d.in_ack  = 1'b0;
        d.ack_drv = 1'b0;
        d.sda_drv = 1'b0;
      end else if (i2c_stop) begin
        d.ph      = PH_IDLE;
        d.in_ack  = 1'b0;
        d.ack_drv = 1'b0;
        d.sda_drv = 1'b0;
      end else if (q.in_ack) begin
        if (scl_fall && !q.ack_drv) begin
          d.sda_drv = q.do_ack;
          d.ack_drv = 1'b1;
        end else if (scl_fall) begin
          d.sda_drv = (q.ph == PH_RDATA) && !q.txreg[7];
          d.in_ack  = 1'b0;
          d.ack_drv = 1'b0;
          d.bitcnt  = 3'h0;
        end
      end else begin
        case (q.ph)
          PH_DEVADDR, PH_SUBADDR, PH_WDATA: begin
            if (scl_rise) begin
              d.shreg  = byte_in;
              d.bitcnt = q.bitcnt + 3'h1;
              if (q.bitcnt == LAST_BIT) begin
                d.in_ack = 1'b1;
                d.do_ack = 1'b1;
                case (q.ph)
                  PH_DEVADDR: begin
                    if (byte_in[7:1] == dev_addr) begin
                      d.rd       = byte_in[0];
                      d.rd_pulse = byte_in[0];
                      d.ph       = byte_in[0] ? PH_RDATA : PH_SUBADDR;
                    end else begin
                      d.in_ack = 1'b0;
                      d.ph     = PH_IGNORE;
                    end
                  end
                  PH_SUBADDR: begin
                    d.raddr   = byte_in[6:3];
                    d.chan_ok = byte_in[2:1] == CHAN_VALID;
                    d.ph      = PH_WDATA;
                  end
                  default: begin
                    d.do_ack   = !refuse;
                    d.wr_pulse = q.chan_ok && !refuse;
                    d.wdata    = byte_in;
                  end
                endcase
              end
            end
          end
          PH_RDATA: begin
            if (scl_rise) begin
              d.bitcnt = q.bitcnt + 3'h1;
              if (q.bitcnt == LAST_BIT) begin
                d.ph = PH_RD_MACK;
              end
            end else if (scl_fall && q.bitcnt != 3'h0) begin
              d.txreg   = {q.txreg[6:0], 1'b1};
              d.sda_drv = !q.txreg[6];
            end
          end
          PH_RD_MACK: begin
            if (scl_fall) begin
              d.sda_drv = 1'b0;
            end else if (scl_rise) begin
              d.rd_pulse = !sda;
              d.ph       = sda ? PH_IGNORE : PH_RD_NEXT;
            end
          end
          PH_RD_NEXT: begin
            if (scl_fall) begin
              d.sda_drv = !q.txreg[7];
              d.bitcnt  = 3'h0;
              d.ph      = PH_RDATA;
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      d.sda_drv = 1'b0;
      d.in_ack  = 1'b0;
      d.ack_drv = 1'b0;
      if (cs) begin
        d.ph     = PH_IDLE;
        d.bitcnt = 3'h0;
      end else if (q.cs_d) begin
        d.ph     = PH_SPI_CMD;
        d.bitcnt = 3'h0;
      end else if (scl_rise && (q.ph == PH_SPI_CMD || q.ph == PH_SPI_DATA)) begin
        d.shreg  = byte_in;
        d.bitcnt = q.bitcnt + 3'h1;
        if (q.bitcnt == LAST_BIT) begin
          if (q.ph == PH_SPI_CMD) begin
            d.rd       = byte_in[7];
            d.raddr    = byte_in[6:3];
            d.chan_ok  = byte_in[2:1] == CHAN_VALID;
            d.rd_pulse = byte_in[7];
            d.ph       = PH_SPI_DATA;
          end else if (q.rd) begin
            d.rd_pulse = 1'b1;
          end else begin
            d.wr_pulse = q.chan_ok && !refuse;
            d.wdata    = byte_in;
          end
        end
      end else if (scl_fall && q.ph == PH_SPI_DATA && q.rd && q.bitcnt != 3'h0) begin
        d.txreg = {q.txreg[6:0], 1'b1};
      end
    end
    d.so = !sel && d.ph == PH_SPI_DATA && d.rd && d.txreg[7];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign sda_o       = 1'b0;
  assign sda_oe_o    = q.sda_drv && sel;
  assign so_o        = q.so;
  assign reg_addr_o  = q.raddr;
  assign reg_wdata_o = q.wdata;
  assign reg_wr_o    = q.wr_pulse;
  assign reg_rd_o    = q.rd_pulse;
  assign irq_tx_n_o  = q.irq_tx_n;
  assign irq_rx_n_o  = q.irq_rx_n;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ack_open;
    sel && !i2c_start && !i2c_stop && q.in_ack && !q.ack_drv && q.do_ack && scl_fall;
  endsequence

  sequence s_spi_read_cmd;
    !sel && !cs && !q.cs_d && q.ph == PH_SPI_CMD && scl_rise && q.bitcnt == LAST_BIT
      && q.shreg[6];
  endsequence

  chk_ack_drive_low: assert property (s_ack_open ##1 sel |-> sda_oe_o)
    else $error("acknowledge not driven");
  chk_nack_release: assert property (sel && q.in_ack && q.ack_drv && !q.do_ack
    |-> !sda_oe_o)
    else $error("refused byte was acknowledged");
  chk_refused_discard: assert property (reg_wr_o && reg_addr_o == REG_ADDR_THR
    |-> !$past(tx_fifo_full_i))
    else $error("write to full transmit FIFO passed");
  chk_channel_gate: assert property (reg_wr_o |-> q.chan_ok)
    else $error("write with invalid channel");
  chk_spi_read_cmd: assert property (s_spi_read_cmd |=> reg_rd_o ##1 !reg_rd_o)
    else $error("read command gave no single read strobe");
  chk_spi_idle_out: assert property (!sel && cs |=> !so_o && q.ph == PH_IDLE)
    else $error("slave output active while deselected");
  chk_addr_mismatch: assert property (sel && !i2c_start && !i2c_stop && !q.in_ack
    && q.ph == PH_DEVADDR && scl_rise && q.bitcnt == LAST_BIT && byte_in[7:1] != dev_addr
    |=> q.ph == PH_IGNORE && !q.in_ack)
    else $error("foreign address accepted");
  chk_irq_tx_auto: assert property (auto_line_direction_mode_i && transmitter_empty_i
    ##1 $stable(transmitter_empty_i) |-> !irq_tx_n_o)
    else $error("transmit interrupt pin high with empty transmitter");
  chk_irq_tx_plain: assert property (!auto_line_direction_mode_i && !fifo_enable_i
    |=> irq_tx_n_o == $past(thr_full_i))
    else $error("transmit interrupt pin does not follow holding register");
  chk_irq_rx_level: assert property (fifo_enable_i && rx_above_trigger_i
    ##1 fifo_enable_i && rx_above_trigger_i |-> !irq_rx_n_o)
    else $error("receive interrupt pin high above trigger");
  chk_reset_outs: assert property (disable iff (1'b0) !rst_n_i |=> !sda_oe_o && !so_o
    && !reg_wr_o && !reg_rd_o)
    else $error("outputs not at default after reset");

endmodule // ushp_serial_host_port

/* verification/ushp_host_model.sv */
// Behavioural I2C and SPI bus master that drives the serial host port pins.
`timescale 1ns/1ps
module ushp_host_model (
  // Pins towards the device.
  output logic      scl_o,
  output logic      pull_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic sda_i,
  input  wire logic so_i
);
  localparam time Q = 40ns;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic clk_bit(output logic v);
    #(Q);
    scl_o = 1'b1;
    #(Q);
    v = sda_i;
    #(Q);
    scl_o = 1'b0;
    #(Q);
  endtask
  task automatic start();
    pull_o = 1'b0;
    #(Q);
    scl_o = 1'b1;
    #(2*Q);
    pull_o = 1'b1;
    #(Q);
    scl_o = 1'b0;
    #(Q);
  endtask
  task automatic stop();
    pull_o = 1'b1;
    #(Q);
    scl_o = 1'b1;
    #(2*Q);
    pull_o = 1'b0;
    #(2*Q);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      pull_o = ~b[i];
      clk_bit(v);
    end
    pull_o = 1'b0;
    clk_bit(v);
    ack = ~v;
  endtask
  task automatic get(input logic mack, output logic [7:0] b);
    logic v;
    pull_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v);
      b[i] = v;
    end
    pull_o = mack;
    clk_bit(v);
  endtask
  task automatic spi(input logic [15:0] w, output logic [7:0] r);
    scl_o = 1'b0;
    cs_n_o = 1'b0;
    #(2*Q);
    for (int i = 15; i >= 0; i--) begin
      si_o = w[i];
      #(2*Q);
      scl_o = 1'b1;
      if (i < 8) r[i] = so_i;
      #(2*Q);
      scl_o = 1'b0;
    end
    #(2*Q);
    cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule // ushp_host_model

/* verification/test_uart_serial_host_port.sv */
// Self-checking bench for the serial host port.
`timescale 1ns/1ps
module test_uart_serial_host_port;
  import ushp_pkg::*;
  logic        clk_sys_i, rst_n_i, sel, sda, sda_oe, so, wr, rd, full, fe, ad, th, ab;
  logic        em, rh, rab, itx, irx, a1, a2, scl, pull, cs_n, si, sdo;
  logic [1:0]  hs, ls;
  logic [3:0]  addr, wa, rga, rg;
  logic [7:0]  wd, rdata, wv, got, d, s;
  logic [31:0] seed, r;
  int          err_total, cmp_count, nw, nr, cyc, n, nw0, nr0;
  wire         st_hi = hs == STRAP_SCL ? scl : hs == STRAP_SDA ? sda : hs == STRAP_VCC;
  wire         st_lo = ls == STRAP_SCL ? scl : ls == STRAP_SDA ? sda : ls == STRAP_VCC;
  assign sda = ~(pull | sda_oe);
  ushp_serial_host_port dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .i2c_spi_n_sel_i(sel),
    .address_strap_high_i(st_hi), .address_strap_low_i(st_lo), .scl_i(scl), .sda_i(sda),
    .sda_o(sdo), .sda_oe_o(sda_oe), .cs_n_i(cs_n), .si_i(si), .so_o(so), .reg_addr_o(addr),
    .reg_wdata_o(wd), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata), .tx_fifo_full_i(full),
    .fifo_enable_i(fe), .auto_line_direction_mode_i(ad), .thr_full_i(th),
    .tx_above_trigger_i(ab), .transmitter_empty_i(em), .rx_data_held_i(rh),
    .rx_above_trigger_i(rab), .irq_tx_n_o(itx), .irq_rx_n_o(irx));
  ushp_host_model m (.scl_o(scl), .pull_o(pull), .cs_n_o(cs_n), .si_o(si), .sda_i(sda),
    .so_i(so));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (wr) begin
      nw++;
      wa = addr;
      wv = wd;
    end
    if (rd) begin
      nr++;
      rga = addr;
    end
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] dev(input logic [1:0] h, input logic [1:0] l);
    return {I2C_ADDR_PREFIX, h[0], l};
  endfunction
  function automatic logic tx_exp(input logic f, a, t, b, e);
    return a ? (f ? b && !e : !e) : (f ? b : t);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse_reset();
    @(posedge clk_sys_i);
    #1 rst_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic pick(input logic [1:0] ch, input logic f);
    @(posedge clk_sys_i);
    #1;
    r = xs();
    rg = r[3:0];
    d = r[11:4];
    rdata = r[19:12];
    s = {r[20], rg, ch, r[21]};
    full = f;
  endtask
  task automatic i2c_wr(input logic [6:0] a);
    logic x;
    m.start();
    m.put({a, 1'b0}, a1);
    m.put(s, x);
    m.put(d, a2);
    m.stop();
  endtask
  task automatic i2c_rd(input logic [6:0] a);
    logic x;
    m.start();
    m.put({a, 1'b0}, x);
    m.put(s, x);
    m.start();
    m.put({a, 1'b1}, a1);
    m.get(1'b0, got);
    m.stop();
  endtask
  initial begin
    seed = 32'hED94;
    rst_n_i = 1'b0;
    sel = 1'b1;
    {hs, ls, full, fe, ad, th, ab, em, rh, rab, rdata} = '0;
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    for (int k = 0; k < 16; k++) begin
      {hs, ls} = k[3:0];
      pulse_reset();
      pick(CHAN_VALID, 1'b0);
      n = nw;
      i2c_wr(dev(hs, ls));
      check("write ack", {a1, a2}, 2'h3);
      check("write place", {wa, wv, nw[7:0]}, {rg, d, n[7:0] + 8'h01});
      n = nr;
      i2c_rd(dev(hs, ls));
      check("read", {a1, got, rga, nr[7:0]}, {1'b1, rdata, rg, n[7:0] + 8'h01});
    end
    n = nw;
    pick(CHAN_VALID, 1'b0);
    i2c_wr(dev(hs, ls) ^ 7'h04);
    check("foreign address", {a1, nw[7:0]}, {1'b0, n[7:0]});
    pick(CHAN_VALID, 1'b1);
    s[6:3] = REG_ADDR_THR;
    i2c_wr(dev(hs, ls));
    check("refused write", {a1, a2, nw[7:0]}, {2'h2, n[7:0]});
    pick(2'h2, 1'b0);
    i2c_wr(dev(hs, ls));
    check("other channel", {a2, nw[7:0]}, {1'b1, n[7:0]});
    i2c_rd(dev(hs, ls));
    check("other channel read", got, READ_FILL);
    sel = 1'b0;
    for (int k = 0; k < 8; k++) begin
      repeat (6) @(posedge clk_sys_i);
      pick(CHAN_VALID, 1'b0);
      nw0 = nw;
      nr0 = nr;
      m.spi({k[0], s[6:0], d}, got);
      check("spi strobes", nw - nw0 + 2 * (nr - nr0), k[0] ? 4 : 1);
      if (k[0])
        check("spi read", {got, rga}, {rdata, rg});
      else
        check("spi write", {wa, wv}, {rg, d});
    end
    for (int k = 0; k < 40; k++) begin
      pick(CHAN_VALID, 1'b0);
      {fe, ad, th, ab, em, rh, rab} = r[28:22];
      repeat (2) @(posedge clk_sys_i);
      #1;
      check("tx irq", itx, tx_exp(fe, ad, th, ab, em));
      check("rx irq", irx, fe ? !rab : !rh);
    end
    rst_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check("reset outputs", {sdo, sda_oe, so, wr, rd, addr, itx, irx}, 11'h001);
    wrap_up();
  end
endmodule // test_uart_serial_host_port
